// >>> hdl/rbc_pkg.sv
// Shared constants, types and register map of the baseband register bank
`default_nettype none
package rbc_pkg;
  // Register offsets
  localparam logic [5:0] ADDR_TX_BYTE = 6'h0f;
  localparam logic [5:0] ADDR_TX_MASK = 6'h10;
  localparam logic [5:0] ADDR_CODE_LO = 6'h11;
  localparam logic [5:0] ADDR_CODE_HI = 6'h18;
  localparam logic [5:0] ADDR_ZERO_LIM = 6'h19;
  localparam logic [5:0] ADDR_ONE_LIM = 6'h1a;
  localparam logic [5:0] ADDR_WAKE_EN = 6'h1c;
  localparam logic [5:0] ADDR_WAKE_STAT = 6'h1d;
  localparam logic [5:0] ADDR_ANALOG = 6'h20;
  localparam logic [5:0] ADDR_CHANNEL = 6'h21;
  localparam logic [5:0] ADDR_STRENGTH = 6'h22;
  localparam logic [5:0] ADDR_POWER = 6'h23;
  localparam logic [5:0] ADDR_PWR_CTL = 6'h2e;
  localparam logic [5:0] ADDR_CARRIER = 6'h2f;
  localparam logic [5:0] ADDR_FID_LO = 6'h3c;
  localparam logic [5:0] ADDR_FID_HI = 6'h3f;
  // Reset values
  localparam logic [63:0] CODE_RESET = 64'h1e8b6a3de0e9b222;
  localparam logic [6:0] ZERO_LIM_RESET = 7'h08;
  localparam logic [6:0] ONE_LIM_RESET = 7'h38;
  // Analog control fields
  localparam int AN_WRITE_EN = 6;
  localparam int AN_FID_EN = 5;
  localparam int AN_AMP_OE = 2;
  localparam int AN_AMP_INV = 1;
  localparam int AN_SOFT_RST = 0;
  localparam logic [7:0] AN_STORE_MASK = 8'h66;
  localparam int STRENGTH_VALID = 5;
  localparam int FLAG_BIT = 7;
  // Serial command byte fields
  localparam int CMD_WRITE = 7;
  localparam int CMD_BURST = 6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Chip timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CHIP_PERIOD_NS = 1000;
  localparam int CHIP_CYCLES = CHIP_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [6:0] CHIP_CNT_LAST = 7'(CHIP_CYCLES - 1);
  localparam logic [5:0] CHIP_LAST_FULL = 6'h3f;
  localparam logic [5:0] CHIP_LAST_HALF = 6'h1f;
  localparam logic [11:0] SYNTH_BASE_MHZ = 12'h960;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} rbc_tx_state_type;
  typedef struct packed {
    logic ssN;
    logic sck;
    logic mosi;
  } rbc_spi_in_type;
  typedef struct packed {
    logic chip;
    logic valid;
  } rbc_chip_type;
endpackage
`default_nettype wire

// >>> hdl/rbc_radio_baseband_config_regs.sv
// Baseband register bank with serial host port, chip serializer and correlator
`default_nettype none
module rbc_radio_baseband_config_regs #(
  parameter logic [31:0] FACTORY_ID = 32'h5a5a0001 // Arbitrary neutral value
) (
  input wire logic mclk,
  input wire logic rst,
  input wire rbc_pkg::rbc_spi_in_type spiIn,
  output logic spiMiso,
  output logic spiMisoOe,
  input wire logic txEnable,
  input wire logic rxEnable,
  input wire logic halfCodeMode,
  input wire logic sleepRequestN,
  input wire logic [4:0] rssiSample,
  input wire rbc_pkg::rbc_chip_type rxChipIn,
  output rbc_pkg::rbc_chip_type txChipOut,
  output logic rxBit,
  output logic rxBitValid,
  output logic irq,
  output logic ampCtlOut,
  output logic ampCtlOe,
  output logic [6:0] rfChannel,
  output logic [11:0] synthFreqMhz,
  output logic [2:0] ampGain,
  output logic powerSaveEn,
  output logic carrierOverride,
  output logic factoryIdPowerEn
);
  // Last chip of a bit for the selected code length
  function automatic logic lastChip(input logic [5:0] idx, input logic half);
    lastChip = half ? (idx == rbc_pkg::CHIP_LAST_HALF) : (idx == rbc_pkg::CHIP_LAST_FULL);
  endfunction

  logic sckPrev;
  logic [2:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] shiftOut;
  logic hdrDone;
  logic cmdWrite;
  logic cmdBurst;
  logic [5:0] addr;
  logic sckRise;
  logic byteDone;
  logic [7:0] byteVal;
  logic wrStrobe;
  logic rdStrobe;
  logic [5:0] rdAddr;
  logic [7:0] readData;
  logic softRst;
  logic [7:0] txByte;
  logic [7:0] txMask;
  logic [63:0] spreadCode;
  logic [6:0] zeroLimit;
  logic [6:0] oneLimit;
  logic wakeEn;
  logic wakeStat;
  logic [7:0] analogCtl;
  logic [6:0] chanReg;
  logic [5:0] strength;
  logic [2:0] powerReg;
  logic pwrCtl;
  logic carrierReg;
  logic sleepPrev;
  logic wakeEvent;
  logic rxEnPrev;
  logic [6:0] chipDiv;
  logic chipTick;
  rbc_pkg::rbc_tx_state_type txState;
  logic txPending;
  logic [7:0] dataSh;
  logic [7:0] validSh;
  logic [5:0] txIdx;
  logic txChip;
  logic [5:0] rxIdx;
  logic [6:0] matchCnt;
  logic [6:0] matchTotal;

  // Serial port framing, mode 0, most significant bit first
  assign sckRise = spiIn.sck & ~sckPrev & ~spiIn.ssN;
  assign byteDone = sckRise && (bitCnt == rbc_pkg::BIT_LAST);
  assign byteVal = {shiftIn[6:0], spiIn.mosi};
  assign wrStrobe = byteDone && hdrDone && cmdWrite;
  // Header of a read, or the next byte of a burst read, fetches data
  assign rdStrobe = byteDone && ((!hdrDone && !byteVal[rbc_pkg::CMD_WRITE]) ||
                    (hdrDone && !cmdWrite && cmdBurst));
  assign rdAddr = hdrDone ? 6'(addr + 6'h01) : byteVal[5:0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sckPrev <= 1'b0;
      bitCnt <= 3'h0;
      shiftIn <= 8'h00;
      hdrDone <= 1'b0;
      cmdWrite <= 1'b0;
      cmdBurst <= 1'b0;
      addr <= 6'h00;
    end else begin
      sckPrev <= spiIn.sck;
      if (spiIn.ssN) begin
        bitCnt <= 3'h0;
        hdrDone <= 1'b0;
      end else if (sckRise) begin
        shiftIn <= byteVal;
        bitCnt <= 3'(bitCnt + 3'h1);
        if (byteDone && !hdrDone) begin
          hdrDone <= 1'b1;
          cmdWrite <= byteVal[rbc_pkg::CMD_WRITE];
          cmdBurst <= byteVal[rbc_pkg::CMD_BURST];
          addr <= byteVal[5:0];
        end else if (byteDone && cmdBurst) begin
          addr <= 6'(addr + 6'h01);
        end
      end
    end
  end

  // Read data shifts on the rising edge the host has just sampled
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shiftOut <= 8'h00;
    end else if (rdStrobe) begin
      shiftOut <= readData;
    end else if (sckRise && hdrDone) begin
      shiftOut <= {shiftOut[6:0], 1'b0};
    end
  end
  assign spiMiso = shiftOut[7];
  assign spiMisoOe = ~spiIn.ssN & hdrDone & ~cmdWrite;

  // Read multiplexer
  always_comb begin
    readData = 8'h00;
    case (rdAddr)
      rbc_pkg::ADDR_TX_BYTE: readData = txByte;
      rbc_pkg::ADDR_TX_MASK: readData = txMask;
      rbc_pkg::ADDR_ZERO_LIM: readData = {1'b0, zeroLimit};
      rbc_pkg::ADDR_ONE_LIM: readData = {1'b0, oneLimit};
      rbc_pkg::ADDR_WAKE_EN: readData = {7'h00, wakeEn};
      rbc_pkg::ADDR_WAKE_STAT: readData = {7'h00, wakeStat};
      rbc_pkg::ADDR_ANALOG: readData = analogCtl;
      rbc_pkg::ADDR_CHANNEL: readData = {1'b0, chanReg};
      rbc_pkg::ADDR_STRENGTH: readData = {2'h0, strength};
      rbc_pkg::ADDR_POWER: readData = {5'h00, powerReg};
      rbc_pkg::ADDR_PWR_CTL: readData = {pwrCtl, 7'h00};
      rbc_pkg::ADDR_CARRIER: readData = {carrierReg, 7'h00};
      default: begin
        if (rdAddr >= rbc_pkg::ADDR_CODE_LO && rdAddr <= rbc_pkg::ADDR_CODE_HI) begin
          readData = spreadCode[{3'(rdAddr - rbc_pkg::ADDR_CODE_LO), 3'h0} +: 8];
        end else if (rdAddr >= rbc_pkg::ADDR_FID_LO && analogCtl[rbc_pkg::AN_FID_EN]) begin
          readData = FACTORY_ID[{2'(rdAddr - rbc_pkg::ADDR_FID_LO), 3'h0} +: 8];
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      softRst <= 1'b0;
    end else begin
      softRst <= wrStrobe && (addr == rbc_pkg::ADDR_ANALOG) && byteVal[rbc_pkg::AN_SOFT_RST];
    end
  end

  // Host-written configuration; soft reset restores the same defaults
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txMask <= 8'h00;
      spreadCode <= rbc_pkg::CODE_RESET;
      zeroLimit <= rbc_pkg::ZERO_LIM_RESET;
      oneLimit <= rbc_pkg::ONE_LIM_RESET;
      wakeEn <= 1'b0;
      analogCtl <= 8'h00;
      chanReg <= 7'h00;
      powerReg <= 3'h0;
    end else if (softRst) begin
      txMask <= 8'h00;
      spreadCode <= rbc_pkg::CODE_RESET;
      zeroLimit <= rbc_pkg::ZERO_LIM_RESET;
      oneLimit <= rbc_pkg::ONE_LIM_RESET;
      wakeEn <= 1'b0;
      analogCtl <= 8'h00;
      chanReg <= 7'h00;
      powerReg <= 3'h0;
    end else if (wrStrobe) begin
      case (addr)
        rbc_pkg::ADDR_TX_MASK: txMask <= byteVal;
        rbc_pkg::ADDR_ZERO_LIM: zeroLimit <= byteVal[6:0];
        rbc_pkg::ADDR_ONE_LIM: oneLimit <= byteVal[6:0];
        rbc_pkg::ADDR_WAKE_EN: wakeEn <= byteVal[0];
        // reserved and reset bits not stored
        rbc_pkg::ADDR_ANALOG: analogCtl <= byteVal & rbc_pkg::AN_STORE_MASK;
        rbc_pkg::ADDR_CHANNEL: chanReg <= byteVal[6:0];
        rbc_pkg::ADDR_POWER: powerReg <= byteVal[2:0];
        default: begin
          if (addr >= rbc_pkg::ADDR_CODE_LO && addr <= rbc_pkg::ADDR_CODE_HI) begin
            spreadCode[{3'(addr - rbc_pkg::ADDR_CODE_LO), 3'h0} +: 8] <= byteVal;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwrCtl <= 1'b0;
      carrierReg <= 1'b0;
    end else if (softRst) begin
      pwrCtl <= 1'b0;
      carrierReg <= 1'b0;
    end else if (wrStrobe && analogCtl[rbc_pkg::AN_WRITE_EN]) begin
      if (addr == rbc_pkg::ADDR_PWR_CTL) pwrCtl <= byteVal[rbc_pkg::FLAG_BIT];
      if (addr == rbc_pkg::ADDR_CARRIER) carrierReg <= byteVal[rbc_pkg::FLAG_BIT];
    end
  end

  // wakeup on release of the sleep pin
  assign wakeEvent = sleepRequestN & ~sleepPrev;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sleepPrev <= 1'b1;
      wakeStat <= 1'b0;
    end else begin
      sleepPrev <= sleepRequestN;
      // set needs no enable, beats clear-on-read
      if (wakeEvent) wakeStat <= 1'b1;
      else if (rdStrobe && rdAddr == rbc_pkg::ADDR_WAKE_STAT) wakeStat <= 1'b0;
      else if (softRst) wakeStat <= 1'b0;
    end
  end
  assign irq = wakeStat & wakeEn;

  // one strength sample per receive entry
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxEnPrev <= 1'b0;
      strength <= 6'h00;
    end else begin
      rxEnPrev <= rxEnable;
      if (softRst) strength <= 6'h00;
      else if (rxEnable && !rxEnPrev) strength <= {1'b1, rssiSample};
    end
  end

  // Chip rate divider
  assign chipTick = (chipDiv == rbc_pkg::CHIP_CNT_LAST);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) chipDiv <= 7'h00;
    else if (chipTick) chipDiv <= 7'h00;
    else chipDiv <= 7'(chipDiv + 7'h01);
  end

  // Transmit data byte; a write arms the serializer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txByte <= 8'h00;
      txPending <= 1'b0;
    end else if (softRst) begin
      txByte <= 8'h00;
      txPending <= 1'b0;
    end else if (wrStrobe && addr == rbc_pkg::ADDR_TX_BYTE) begin
      txByte <= byteVal;
      txPending <= 1'b1;
    end else if (txState == rbc_pkg::TX_IDLE && txEnable && chipTick) begin
      txPending <= 1'b0;
    end
  end

  // Serializer; dropping transmit mode aborts the byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      txState <= rbc_pkg::TX_IDLE;
      dataSh <= 8'h00;
      validSh <= 8'h00;
      txIdx <= 6'h00;
      txChip <= 1'b0;
    end else if (softRst || !txEnable) begin
      txState <= rbc_pkg::TX_IDLE;
      validSh <= 8'h00;
      txIdx <= 6'h00;
    end else if (chipTick) begin
      case (txState)
        rbc_pkg::TX_IDLE: begin
          if (txPending && txMask != 8'h00) begin
            dataSh <= txByte;
            validSh <= txMask;
            txIdx <= 6'h00;
            txState <= rbc_pkg::TX_SEND;
          end
        end
        rbc_pkg::TX_SEND: begin
          txChip <= validSh[0] ? (spreadCode[txIdx] ~^ dataSh[0]) : spreadCode[txIdx];
          // 32 or 64 chips per bit
          if (lastChip(txIdx, halfCodeMode)) begin
            txIdx <= 6'h00;
            dataSh <= {1'b0, dataSh[7:1]};
            validSh <= {1'b0, validSh[7:1]};
            // stop once no valid bits remain
            if (validSh[7:1] == 7'h00) txState <= rbc_pkg::TX_IDLE;
          end else begin
            txIdx <= 6'(txIdx + 6'h01);
          end
        end
        default: txState <= rbc_pkg::TX_IDLE;
      endcase
    end
  end
  // transmit status only in transmit mode
  assign txChipOut = '{chip: txChip, valid: (txState == rbc_pkg::TX_SEND) & txEnable};

  // Correlator, one match count per received bit
  assign matchTotal = 7'(matchCnt + {6'h00, rxChipIn.chip == spreadCode[rxIdx]});
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rxIdx <= 6'h00;
      matchCnt <= 7'h00;
      rxBit <= 1'b0;
      rxBitValid <= 1'b0;
    end else begin
      rxBitValid <= 1'b0;
      if (softRst || !rxEnable) begin
        rxIdx <= 6'h00;
        matchCnt <= 7'h00;
      end else if (rxChipIn.valid) begin
        if (lastChip(rxIdx, halfCodeMode)) begin
          rxIdx <= 6'h00;
          matchCnt <= 7'h00;
          if (matchTotal >= oneLimit) begin
            rxBit <= 1'b1;
            rxBitValid <= 1'b1;
          end else if (matchTotal <= zeroLimit) begin
            rxBit <= 1'b0;
            rxBitValid <= 1'b1;
          end
        end else begin
          rxIdx <= 6'(rxIdx + 6'h01);
          matchCnt <= matchTotal;
        end
      end
    end
  end

  // Amplifier pin follows transmit mode; polarity changes land next cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ampCtlOut <= 1'b0;
      ampCtlOe <= 1'b0;
    end else begin
      ampCtlOe <= analogCtl[rbc_pkg::AN_AMP_OE];
      // invert bit makes it active low
      ampCtlOut <= analogCtl[rbc_pkg::AN_AMP_OE] & (txEnable ^ analogCtl[rbc_pkg::AN_AMP_INV]);
    end
  end

  // channel offset from base in 1 MHz steps
  assign synthFreqMhz = 12'(rbc_pkg::SYNTH_BASE_MHZ + {5'h00, chanReg});
  assign rfChannel = chanReg;
  assign ampGain = powerReg;
  assign powerSaveEn = pwrCtl;
  assign carrierOverride = carrierReg;
  // factory serial powered only when enabled
  assign factoryIdPowerEn = analogCtl[rbc_pkg::AN_FID_EN];

  property p_wake_irq;
    @(posedge mclk) disable iff (rst) irq == (wakeStat && wakeEn);
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("irq mismatch");

  property p_wake_set;
    @(posedge mclk) disable iff (rst) (wakeEvent && !softRst) |=> wakeStat;
  endproperty
  a_wake_set: assert property (p_wake_set) else $error("wake not set");

  property p_wake_clear;
    @(posedge mclk) disable iff (rst)
      (rdStrobe && rdAddr == rbc_pkg::ADDR_WAKE_STAT && !wakeEvent) |=> !wakeStat;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake not cleared");

  property p_gate_write;
    @(posedge mclk) disable iff (rst)
      (!analogCtl[rbc_pkg::AN_WRITE_EN] && !softRst) |=> $stable(pwrCtl) && $stable(carrierReg);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gated write");

  property p_soft_reset;
    @(posedge mclk) disable iff (rst)
      softRst |=> chanReg == 7'h00 && oneLimit == rbc_pkg::ONE_LIM_RESET &&
        zeroLimit == rbc_pkg::ZERO_LIM_RESET && analogCtl == 8'h00 && !softRst;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset");

  property p_amp_pin;
    @(posedge mclk) disable iff (rst)
      ##1 ampCtlOe == $past(analogCtl[rbc_pkg::AN_AMP_OE]) &&
        (!ampCtlOe || ampCtlOut == $past(txEnable ^ analogCtl[rbc_pkg::AN_AMP_INV]));
  endproperty
  a_amp_pin: assert property (p_amp_pin) else $error("amp pin");

  property p_tx_qual;
    @(posedge mclk) disable iff (rst) !txEnable |-> !txChipOut.valid;
  endproperty
  a_tx_qual: assert property (p_tx_qual) else $error("tx without mode");

  property p_rx_decide;
    @(posedge mclk) disable iff (rst)
      (rxEnable && !softRst && rxChipIn.valid && lastChip(rxIdx, halfCodeMode) &&
       matchTotal >= oneLimit) |=> rxBitValid && rxBit;
  endproperty
  a_rx_decide: assert property (p_rx_decide) else $error("one not decided");

  property p_rx_zero;
    @(posedge mclk) disable iff (rst)
      (rxEnable && !softRst && rxChipIn.valid && lastChip(rxIdx, halfCodeMode) &&
       matchTotal < oneLimit && matchTotal <= zeroLimit) |=> rxBitValid && !rxBit;
  endproperty
  a_rx_zero: assert property (p_rx_zero) else $error("zero not decided");

  property p_strength;
    @(posedge mclk) disable iff (rst)
      (rxEnable && !rxEnPrev && !softRst) |=> strength == {1'b1, $past(rssiSample)};
  endproperty
  a_strength: assert property (p_strength) else $error("strength sample");

  property p_tx_stop;
    @(posedge mclk) disable iff (rst)
      txState == rbc_pkg::TX_SEND |-> validSh != 8'h00;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("sent without valid");
endmodule
`default_nettype wire

// >>> testbench/rbc_host_model.sv
// Host serial master model that frames register reads and writes
`default_nettype none
module rbc_host_model (
  input wire logic mclk,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  output rbc_pkg::rbc_spi_in_type spiIn,
  output logic [7:0] rdData,
  output logic rdOe,
  output logic rdValid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus: deselected, clock low
  initial begin
    spiIn = '{ssN: 1'b1, sck: 1'b0, mosi: 1'b0};
    rdData = 8'h00;
    rdOe = 1'b0;
    rdValid = 1'b0;
  end
  // One byte MSB first; each clock phase lasts two cycles
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spiIn.mosi <= tx[i];
      repeat (2) @(posedge mclk);
      rx[i] = spiMiso;
      spiIn.sck <= 1'b1;
      repeat (2) @(posedge mclk);
      spiIn.sck <= 1'b0;
    end
  endtask
  // Header plus one data byte; read result shown for one cycle
  task automatic access(input logic wr, input logic [5:0] addr, input logic [7:0] wdata);
    logic [7:0] rx;
    logic oe;
    @(posedge mclk);
    spiIn.ssN <= 1'b0;
    repeat (2) @(posedge mclk);
    shift_byte({wr, 1'b0, addr}, rx);
    // Drive enable as seen once the header is taken
    oe = spiMisoOe;
    shift_byte(wdata, rx);
    repeat (2) @(posedge mclk);
    spiIn.ssN <= 1'b1;
    rdData <= rx;
    rdOe <= oe;
    rdValid <= !wr;
    @(posedge mclk);
    rdValid <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// >>> testbench/rbc_radio_baseband_config_regs_bench.sv
// Self-checking bench for the baseband register bank
`default_nettype none
module rbc_radio_baseband_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FID = 32'h3c3c0a0a; // Arbitrary value
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic txEnable = 1'b0;
  logic rxEnable = 1'b0;
  logic halfCodeMode = 1'b1;
  logic sleepRequestN = 1'b1;
  logic [4:0] rssiSample = 5'h00;
  rbc_pkg::rbc_chip_type rxChipIn = '{chip: 1'b0, valid: 1'b0};
  rbc_pkg::rbc_chip_type txChipOut;
  rbc_pkg::rbc_spi_in_type spiIn;
  logic spiMiso, spiMisoOe, rxBit, rxBitValid, irq, ampCtlOut, ampCtlOe;
  logic powerSaveEn, carrierOverride, factoryIdPowerEn, rdValid, rdOe;
  logic [6:0] rfChannel;
  logic [11:0] synthFreqMhz;
  logic [2:0] ampGain;
  logic [7:0] rdData;
  logic [7:0] regQ[$];
  logic bitQ[$];
  int fails = 0;
  int n_tests = 0;

  always #4 mclk = ~mclk;

  rbc_radio_baseband_config_regs #(.FACTORY_ID(FID)) uut (
    .mclk(mclk), .rst(rst), .spiIn(spiIn), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .txEnable(txEnable), .rxEnable(rxEnable), .halfCodeMode(halfCodeMode),
    .sleepRequestN(sleepRequestN), .rssiSample(rssiSample), .rxChipIn(rxChipIn),
    .txChipOut(txChipOut), .rxBit(rxBit), .rxBitValid(rxBitValid), .irq(irq),
    .ampCtlOut(ampCtlOut), .ampCtlOe(ampCtlOe), .rfChannel(rfChannel),
    .synthFreqMhz(synthFreqMhz), .ampGain(ampGain), .powerSaveEn(powerSaveEn),
    .carrierOverride(carrierOverride), .factoryIdPowerEn(factoryIdPowerEn)
  );
  rbc_host_model host (
    .mclk(mclk), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .spiIn(spiIn),
    .rdData(rdData), .rdOe(rdOe), .rdValid(rdValid)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask
  // Expected read value is queued before the frame goes out
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    regQ.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask
  task automatic wake_pulse();
    sleepRequestN <= 1'b0;
    repeat (3) @(posedge mclk);
    sleepRequestN <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // Results are matched against the oldest note; a stray bit is a mismatch
  always @(posedge mclk) begin
    if (rdValid === 1'b1) begin
      check(16'(rdData), regQ.size() ? 16'(regQ.pop_front()) : 16'hdead); // reads
      check(16'(rdOe), 16'h0001); // miso driven
    end
    if (rxBitValid === 1'b1) begin
      check(16'(rxBit), bitQ.size() ? 16'(bitQ.pop_front()) : 16'hdead); // bits
    end
  end

  // Bound on the whole run
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    give_verdict();
  end

  initial begin
    logic [6:0] ch;
    logic [4:0] rs;
    void'($urandom(32'hb5c5));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(rbc_pkg::ADDR_TX_MASK, 8'h00);
    for (int i = 0; i < 8; i++) rd(6'(rbc_pkg::ADDR_CODE_LO + i), rbc_pkg::CODE_RESET[8*i+:8]);
    rd(rbc_pkg::ADDR_ZERO_LIM, {1'b0, rbc_pkg::ZERO_LIM_RESET});
    rd(rbc_pkg::ADDR_ONE_LIM, {1'b0, rbc_pkg::ONE_LIM_RESET});
    rd(rbc_pkg::ADDR_STRENGTH, 8'h00);
    rd(6'h30, 8'h00);
    ch = 7'(2 + ($urandom % 78));
    wr(rbc_pkg::ADDR_CHANNEL, {1'b1, ch});
    rd(rbc_pkg::ADDR_CHANNEL, {1'b0, ch});
    check(16'(synthFreqMhz), 16'(rbc_pkg::SYNTH_BASE_MHZ + 12'(ch))); // frequency
    check(16'(rfChannel), 16'(ch)); // channel field
    wr(rbc_pkg::ADDR_POWER, 8'hff);
    rd(rbc_pkg::ADDR_POWER, 8'h07);
    check(16'(ampGain), 16'h0007); // gain field
    wr(rbc_pkg::ADDR_PWR_CTL, 8'h80);
    check(16'(powerSaveEn), 16'h0000); // ignored
    wr(rbc_pkg::ADDR_ANALOG, 8'h40);
    wr(rbc_pkg::ADDR_PWR_CTL, 8'hff);
    wr(rbc_pkg::ADDR_CARRIER, 8'h80);
    rd(rbc_pkg::ADDR_PWR_CTL, 8'h80);
    check(16'({powerSaveEn, carrierOverride}), 16'h0003); // accepted
    rd(rbc_pkg::ADDR_FID_LO, 8'h00);
    wr(rbc_pkg::ADDR_ANALOG, 8'h60);
    check(16'(factoryIdPowerEn), 16'h0001); // power enable
    for (int i = 0; i < 4; i++) rd(6'(rbc_pkg::ADDR_FID_LO + i), FID[8*i+:8]);
    check(16'(ampCtlOe), 16'h0000); // pin off
    wr(rbc_pkg::ADDR_ANALOG, 8'h64);
    check(16'({ampCtlOe, ampCtlOut}), 16'h0002); // active high
    wr(rbc_pkg::ADDR_ANALOG, 8'h66);
    check(16'(ampCtlOut), 16'h0001); // active low
    rd(rbc_pkg::ADDR_ANALOG, 8'h66);
    wake_pulse();
    check(16'(irq), 16'h0000); // masked
    rd(rbc_pkg::ADDR_WAKE_STAT, 8'h01);
    rd(rbc_pkg::ADDR_WAKE_STAT, 8'h00);
    wr(rbc_pkg::ADDR_WAKE_EN, 8'hff);
    rd(rbc_pkg::ADDR_WAKE_EN, 8'h01);
    wake_pulse();
    check(16'(irq), 16'h0001); // wake request
    rd(rbc_pkg::ADDR_WAKE_STAT, 8'h01);
    check(16'(irq), 16'h0000); // cleared by read
    wr(rbc_pkg::ADDR_ZERO_LIM, 8'h04);
    wr(rbc_pkg::ADDR_ONE_LIM, 8'h1c);
    rs = 5'($urandom);
    rssiSample <= rs;
    @(posedge mclk);
    rxEnable <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(rbc_pkg::ADDR_STRENGTH, {3'b001, rs});
    // Code, inverse, undecidable, then 64-chip inverse; 3 errors unless undecidable
    for (int b = 0; b < 4; b++) begin
      if (b != 2) bitQ.push_back(b == 0);
      halfCodeMode <= (b != 3);
      for (int k = 0; k < (b == 3 ? 64 : 32); k++) begin
        @(posedge mclk);
        rxChipIn <= '{chip: rbc_pkg::CODE_RESET[k] ^ (b % 2 == 1) ^ (k < (b == 2 ? 16 : 3)),
                      valid: 1'b1};
        @(posedge mclk);
        rxChipIn.valid <= 1'b0;
      end
      repeat (4) @(posedge mclk);
    end
    check(16'(bitQ.size()), 16'h0000); // all decided
    rxEnable <= 1'b0;
    halfCodeMode <= 1'b1;
    // Serializer: preamble, data 1, preamble, data 0 in half code mode
    wr(rbc_pkg::ADDR_TX_MASK, 8'h0a);
    wr(rbc_pkg::ADDR_TX_BYTE, 8'h06);
    repeat (130) @(posedge mclk);
    check(16'(txChipOut.valid), 16'h0000); // idle without enable
    txEnable <= 1'b1;
    for (int w = 0; w < 200 && txChipOut.valid !== 1'b1; w++) @(posedge mclk);
    // The first chip shows one chip period after valid rises; sample mid-chip
    repeat (187) @(posedge mclk);
    check(16'(ampCtlOut), 16'h0000); // inverted drive
    for (int k = 0; k < 128; k++) begin
      check(16'(txChipOut.chip), 16'(rbc_pkg::CODE_RESET[k%32] ^ (k/32 == 3))); // chips
      repeat (125) @(posedge mclk);
    end
    check(16'(txChipOut.valid), 16'h0000); // stop after last valid
    txEnable <= 1'b0;
    wr(rbc_pkg::ADDR_ANALOG, 8'h01);
    rd(rbc_pkg::ADDR_CHANNEL, 8'h00);
    rd(rbc_pkg::ADDR_ANALOG, 8'h00);
    rd(rbc_pkg::ADDR_TX_MASK, 8'h00);
    check(16'({ampCtlOe, powerSaveEn}), 16'h0000); // outputs cleared
    check(16'(regQ.size()), 16'h0000); // every read answered
    give_verdict();
  end
endmodule
`default_nettype wire
